// ### dv/smw_host_model.sv
// Host side model: accepts output words with optional stalls, sends tick and speed words
`timescale 1ns/10ps
`default_nettype none
module smw_host_model
(
	input wire logic clk_i, // Bench clock
	input wire logic slow_i, // High: stall the port at random
	output logic out_ready_o, // Port accepts a word
	output logic in_valid_o, // Host word valid
	output logic [31:0] in_word_o // Host word
);
	// ==========================================
	// Port acceptance
	initial
	begin
		out_ready_o = 1'b0;
		in_valid_o = 1'b0;
		in_word_o = 32'h0;
	end
	// A slow port drops ready most cycles, so both streams back up
	always @(posedge clk_i)
		out_ready_o <= !slow_i || ($urandom_range(2, 0) == 0);
	// ==========================================
	// Host words into the device
	// One-cycle word; afterwards the bus shows the inverse, not a stale copy
	task automatic send_word(input logic [5:0] code, input logic [23:0] pay);
		@(posedge clk_i);
		in_valid_o <= 1'b1;
		in_word_o <= {2'b00, code, pay};
		@(posedge clk_i);
		in_valid_o <= 1'b0;
		in_word_o <= ~{2'b00, code, pay};
	endtask
endmodule
`default_nettype wire

// ### dv/tb_sensor_measurement_word_output.sv
// Testbench for the measurement word framer: both streams, refusal and host input
`timescale 1ns/10ps
`default_nettype none
module tb_sensor_measurement_word_output;
	import smw_pkg::*;
	localparam int TDIV = 3;
	localparam logic [5:0] ORDER [7] = '{SMW_CODE_GYRO_X, SMW_CODE_GYRO_Y, SMW_CODE_GYRO_Z,
		SMW_CODE_ACC_X, SMW_CODE_ACC_Y, SMW_CODE_ACC_Z, SMW_CODE_TEMP};
	localparam logic [5:0] HOST [8] = '{6'h08, 6'h09, 6'h0a, 6'h0b, 6'h00, 6'h05, 6'h0f, 6'h0c};
	typedef struct packed {
		logic [31:0] w;
		logic sof;
		logic eof;
		logic cal;
		logic [31:0] t;
	} smw_exp_t;
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic sample_stb_i = 1'b0;
	smw_sample_t raw_i = '0;
	smw_sample_t cal_i = '0;
	logic calib_done_i = 1'b0;
	logic [31:0] time_i = 32'h0;
	logic direct_imu_i = 1'b0;
	logic [7:0] raw_rate_i = 8'h00;
	logic [7:0] cal_rate_i = 8'h00;
	logic cfg_stb_i = 1'b0;
	logic fusion_run_i = 1'b0;
	logic slow = 1'b0;
	logic fusion_state_flag_o, out_valid_o, out_ready_i, out_sof_o, out_eof_o, out_cal_o;
	logic [31:0] out_word_o, out_time_o, in_word_i;
	logic in_valid_i, ext_valid_o, ext_backward_o;
	logic [5:0] ext_code_o;
	logic [22:0] ext_ticks_o;
	logic signed [23:0] ext_speed_o;
	smw_exp_t exp_q[$];
	int err_total = 0;
	int n_tests = 0;
	int cyc = 0;
	int cal_cnt = 0;
	logic m_raw = 1'b0;
	logic m_cal = 1'b0;

	always #20 clk_i = ~clk_i;

	smw_framer #(.TEMP_DIV(TDIV)) dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.sample_stb_i(sample_stb_i), .raw_i(raw_i), .cal_i(cal_i), .calib_done_i(calib_done_i),
		.time_i(time_i), .direct_imu_i(direct_imu_i), .raw_rate_i(raw_rate_i),
		.cal_rate_i(cal_rate_i), .cfg_stb_i(cfg_stb_i), .fusion_run_i(fusion_run_i),
		.fusion_state_flag_o(fusion_state_flag_o), .out_valid_o(out_valid_o),
		.out_ready_i(out_ready_i), .out_word_o(out_word_o), .out_sof_o(out_sof_o),
		.out_eof_o(out_eof_o), .out_cal_o(out_cal_o), .out_time_o(out_time_o),
		.in_valid_i(in_valid_i), .in_word_i(in_word_i), .ext_valid_o(ext_valid_o),
		.ext_code_o(ext_code_o), .ext_backward_o(ext_backward_o), .ext_ticks_o(ext_ticks_o),
		.ext_speed_o(ext_speed_o));

	smw_host_model host (.clk_i(clk_i), .slow_i(slow), .out_ready_o(out_ready_i),
		.in_valid_o(in_valid_i), .in_word_o(in_word_i));

	// ==========================================
	// Compare, verdict and hang guard
	task automatic check(input logic [79:0] seen, input logic [79:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			err_total++;
			$display("BAD %0t mismatch seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic close_out();
		$display("checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// Ceiling well above the few hundred cycles the run needs
	always @(posedge clk_i)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			err_total++;
			close_out();
		end
	end

	// ==========================================
	// Reference model of the two streams
	// Every accepted word must be the next one the model predicted; strays count too
	always @(posedge clk_i)
		if (rst_n_i && out_valid_o && out_ready_i)
		begin
			if (exp_q.size() == 0)
				check(1, 0);
			else
				check({out_word_o, out_sof_o, out_eof_o, out_cal_o, out_time_o},
					exp_q.pop_front());
		end

	// Fixed field order; the temperature word is the last so a short message drops it
	task automatic push_msg(input smw_sample_t s, input logic cal, input logic [31:0] t,
		input int nf);
		for (int i = 0; i < nf; i++)
			exp_q.push_back({{2'b00, ORDER[i], s[167 - 24 * i -: 24]},
				i == 0, i == nf - 1, cal, t});
	endtask

	// One sample strobe; take is low when the design should refuse it as busy
	task automatic strobe(input logic take);
		smw_sample_t r;
		smw_sample_t c;
		logic [31:0] t;
		for (int i = 0; i < 7; i++)
		begin
			r[i * 24 +: 24] = 24'($urandom);
			c[i * 24 +: 24] = 24'($urandom);
		end
		t = $urandom;
		@(posedge clk_i);
		sample_stb_i <= 1'b1;
		raw_i <= r;
		cal_i <= c;
		time_i <= t;
		if (take && direct_imu_i && m_raw)
			push_msg(r, 1'b0, t, 7);
		if (take && direct_imu_i && m_cal)
		begin
			push_msg(calib_done_i ? c : r, 1'b1, t, cal_cnt == 0 ? 7 : 6);
			cal_cnt = (cal_cnt + 1) % TDIV;
		end
		@(posedge clk_i);
		sample_stb_i <= 1'b0;
	endtask

	// Wait for the predicted words, bounded, then let the design settle idle
	task automatic drain();
		int k;
		k = 0;
		while (exp_q.size() != 0 && k < 400)
		begin
			@(posedge clk_i);
			k++;
		end
		if (k == 400)
			check(1, 0);
		repeat (6) @(posedge clk_i);
	endtask

	// Rates are cleared after the pulse, so only the captured copy may matter
	task automatic cfg(input logic [7:0] r, input logic [7:0] c);
		@(posedge clk_i);
		raw_rate_i <= r;
		cal_rate_i <= c;
		cfg_stb_i <= 1'b1;
		m_raw = (r != 8'h00);
		m_cal = (c != 8'h00);
		@(posedge clk_i);
		cfg_stb_i <= 1'b0;
		raw_rate_i <= 8'h00;
		cal_rate_i <= 8'h00;
	endtask

	// ==========================================
	// Main sequence
	initial
	begin
		logic [23:0] p;
		logic v;
		void'($urandom(32'h3c7ebf9a));
		repeat (5) @(posedge clk_i);
		rst_n_i <= 1'b1;
		direct_imu_i <= 1'b1;
		strobe(1'b1);
		drain();
		direct_imu_i <= 1'b0;
		cfg(8'h01, 8'h01);
		strobe(1'b1);
		drain();
		direct_imu_i <= 1'b1;
		cfg(8'h01, 8'h00);
		// A second strobe inside a running message would be dropped, so drain between
		repeat (2)
		begin
			strobe(1'b1);
			drain();
		end
		// Both streams with a stalling port; four messages wrap the temperature counter
		cfg(8'($urandom_range(255, 1)), 8'($urandom_range(255, 1)));
		slow <= 1'b1;
		repeat (4)
		begin
			strobe(1'b1);
			drain();
		end
		slow <= 1'b0;
		strobe(1'b1);
		repeat (3) @(posedge clk_i);
		strobe(1'b0);
		drain();
		calib_done_i <= 1'b1;
		cfg(8'h00, 8'h02);
		repeat (3)
		begin
			strobe(1'b1);
			drain();
		end
		// Fusion keeps following its request while raw output is enabled
		cfg(8'h03, 8'h00);
		repeat (4)
		begin
			v = 1'($urandom);
			@(posedge clk_i);
			fusion_run_i <= v;
			@(posedge clk_i);
			@(negedge clk_i);
			check(fusion_state_flag_o, v);
		end
		// Host words: ticks and speed accepted, empty and other codes ignored
		foreach (HOST[i])
		begin
			p = 24'($urandom);
			host.send_word(HOST[i], p);
			@(negedge clk_i);
			if (HOST[i] >= 6'h08 && HOST[i] <= 6'h0b)
				check({ext_valid_o, ext_code_o}, {1'b1, HOST[i]});
			else
				check(ext_valid_o, 0);
			if (HOST[i] >= 6'h08 && HOST[i] <= 6'h0a)
				check({ext_backward_o, ext_ticks_o}, p);
			if (HOST[i] == 6'h0b)
				check({ext_speed_o}, p);
		end
		close_out();
	end
endmodule
`default_nettype wire

// ### verilog/smw_framer.sv
// Sensor measurement word framer: raw and calibrated streams, host input
`timescale 1ns/10ps
`default_nettype none
module smw_framer
	import smw_pkg::*;
#(
	parameter int NUM_FIELDS = SMW_NUM_FIELDS, // Fields per raw message
	parameter int TEMP_DIV = SMW_TEMP_DIV // Calibrated messages per temperature
)
(
	input wire logic clk_i, // 25 MHz clock
	input wire logic rst_n_i, // Async reset, active low
	input wire logic sample_stb_i, // Sensor sample strobe, fixed rate
	input wire smw_sample_t raw_i, // Raw sensor sample set
	input wire smw_sample_t cal_i, // Calibrated sample set
	input wire logic calib_done_i, // Calibration complete
	input wire logic [31:0] time_i, // Sample timestamp
	input wire logic direct_imu_i, // Sensors wired directly
	input wire logic [7:0] raw_rate_i, // Raw output rate setting
	input wire logic [7:0] cal_rate_i, // Calibrated output rate setting
	input wire logic cfg_stb_i, // Rate settings applied
	input wire logic fusion_run_i, // Fusion enabled request
	output logic fusion_state_flag_o, // Fusion running
	output logic out_valid_o, // Output word valid
	input wire logic out_ready_i, // Port accepts word
	output logic [31:0] out_word_o, // Output word
	output logic out_sof_o, // First word of message
	output logic out_eof_o, // Last word of message
	output logic out_cal_o, // Word belongs to calibrated message
	output logic [31:0] out_time_o, // Message timestamp
	input wire logic in_valid_i, // Host word valid
	input wire logic [31:0] in_word_i, // Host word
	output logic ext_valid_o, // External tick or speed accepted
	output logic [5:0] ext_code_o, // External word code
	output logic ext_backward_o, // External direction
	output logic [22:0] ext_ticks_o, // External tick count
	output logic signed [23:0] ext_speed_o // External speed
);
	// ==============================
	// State
	typedef enum logic [2:0] {
		SMW_S_IDLE = 3'b001,
		SMW_S_RAW = 3'b010,
		SMW_S_CAL = 3'b100
	} smw_state_t;

	typedef struct packed {
		smw_state_t st;
		logic [7:0] raw_rate;
		logic [7:0] cal_rate;
		logic [2:0] idx;
		logic [6:0] temp_cnt;
		logic cal_pend;
		logic cal_temp;
		smw_sample_t raw;
		smw_sample_t cal;
		logic [31:0] tstamp;
		logic [31:0] word;
		logic wvalid;
		logic sof;
		logic eof;
		logic is_cal;
		logic ext_valid;
		logic [5:0] ext_code;
		logic ext_back;
		logic [22:0] ext_ticks;
		logic [23:0] ext_speed;
		logic fusion;
	} smw_regs_t;

	smw_regs_t r;
	smw_regs_t next_r;
	logic raw_en;
	logic cal_en;
	logic [5:0] f_code;
	logic [23:0] f_pay;
	logic [31:0] f_word;
	logic f_last;
	smw_field_t in_f;
	smw_sample_t src;

	// ==============================
	// Enables
	// Rate value only gates the stream; cadence always follows the sensors
	assign raw_en = direct_imu_i && (r.raw_rate != 8'h00); // [RL13] [RL15]
	assign cal_en = direct_imu_i && (r.cal_rate != 8'h00); // [RL16] [RL17] [RL15]

	// Field selector: one sample of each type per raw message
	always_comb
	begin
		src = (r.st == SMW_S_CAL) ? r.cal : r.raw;
		f_code = SMW_CODE_NONE;
		f_pay = '0;
		case (r.idx)
			3'h0:
			begin
				f_code = SMW_CODE_GYRO_X;
				f_pay = src.gyro_x;
			end
			3'h1:
			begin
				f_code = SMW_CODE_GYRO_Y;
				f_pay = src.gyro_y;
			end
			3'h2:
			begin
				f_code = SMW_CODE_GYRO_Z;
				f_pay = src.gyro_z;
			end
			3'h3:
			begin
				f_code = SMW_CODE_ACC_X;
				f_pay = src.acc_x;
			end
			3'h4:
			begin
				f_code = SMW_CODE_ACC_Y;
				f_pay = src.acc_y;
			end
			3'h5:
			begin
				f_code = SMW_CODE_ACC_Z;
				f_pay = src.acc_z;
			end
			default:
			begin
				f_code = SMW_CODE_TEMP;
				f_pay = src.temp;
			end
		endcase
	end

	// Calibrated message without temperature ends one field early
	assign f_last = (r.st == SMW_S_CAL && !r.cal_temp) ?
		(r.idx == 3'(NUM_FIELDS - 2)) : (r.idx == 3'(NUM_FIELDS - 1)); // [RL18] [RL11]

	smw_pack u_pack (
		.code_i(f_code),
		.payload_i(f_pay),
		.word_o(f_word)
	);

	smw_unpack u_unpack (
		.word_i(in_word_i),
		.field_o(in_f)
	);

	// Next-state logic
	always_comb
	begin
		next_r = r;
		next_r.ext_valid = 1'b0;
		next_r.fusion = fusion_run_i; // [RL14]
		if (cfg_stb_i)
		begin
			next_r.raw_rate = raw_rate_i;
			next_r.cal_rate = cal_rate_i;
		end
		// Host input: only ticks and speed taken, others ignored
		if (in_valid_i && in_f.valid &&
			(in_f.kind == SMW_K_TICK || in_f.code == SMW_CODE_SPEED)) // [RL10] [RL9]
		begin
			next_r.ext_valid = 1'b1;
			next_r.ext_code = in_f.code;
			next_r.ext_back = in_f.backward;
			next_r.ext_ticks = in_f.ticks;
			next_r.ext_speed = in_f.value;
		end
		// Output word handshake
		if (r.wvalid && out_ready_i)
		begin
			next_r.wvalid = 1'b0;
		end
		case (r.st)
			SMW_S_IDLE:
			begin
				// Samples arriving mid-message are dropped; port too slow
				if (sample_stb_i && (raw_en || cal_en)) // [RL12]
				begin
					next_r.raw = raw_i;
					next_r.cal = calib_done_i ? cal_i : raw_i; // [RL19]
					next_r.tstamp = time_i; // [RL20]
					next_r.idx = '0;
					next_r.cal_pend = cal_en;
					next_r.cal_temp = (r.temp_cnt == 7'h00);
					if (cal_en)
					begin
						next_r.temp_cnt = (r.temp_cnt == 7'(TEMP_DIV - 1)) ?
							7'h00 : r.temp_cnt + 7'h01; // [RL18]
					end
					next_r.st = raw_en ? SMW_S_RAW : SMW_S_CAL;
				end
			end
			SMW_S_RAW, SMW_S_CAL:
			begin
				if (!r.wvalid || out_ready_i)
				begin
					next_r.word = f_word;
					next_r.wvalid = 1'b1;
					next_r.sof = (r.idx == 3'h0);
					next_r.eof = f_last;
					next_r.is_cal = (r.st == SMW_S_CAL);
					next_r.idx = r.idx + 3'h1;
					if (f_last)
					begin
						next_r.idx = '0;
						if (r.st == SMW_S_RAW && r.cal_pend)
							next_r.st = SMW_S_CAL; // [RL20]
						else
							next_r.st = SMW_S_IDLE;
					end
				end
			end
			default:
			begin
				next_r.st = SMW_S_IDLE;
			end
		endcase
	end

	// State register
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			r <= '0;
			r.st <= SMW_S_IDLE;
			r.raw_rate <= SMW_RATE_RST;
			r.cal_rate <= SMW_RATE_RST; // [RL16]
		end
		else
		begin
			r <= next_r;
		end
	end

	assign out_valid_o = r.wvalid;
	assign out_word_o = r.word;
	assign out_sof_o = r.sof;
	assign out_eof_o = r.eof;
	assign out_cal_o = r.is_cal;
	assign out_time_o = r.tstamp;
	assign ext_valid_o = r.ext_valid;
	assign ext_code_o = r.ext_code;
	assign ext_backward_o = r.ext_back;
	assign ext_ticks_o = r.ext_ticks;
	assign ext_speed_o = signed'(r.ext_speed);
	assign fusion_state_flag_o = r.fusion;

	// ==============================
	// Assertions
	AST_NO_EMIT_IF_INDIRECT: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RL15]
		(!direct_imu_i && r.st == SMW_S_IDLE && sample_stb_i) |=> (r.st == SMW_S_IDLE))
		else $error("message started without direct sensors");
	AST_CAL_OFF_AT_START: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RL16]
		(r.cal_rate == 8'h00 && r.st == SMW_S_IDLE) |=> (r.st != SMW_S_CAL))
		else $error("calibrated message while disabled");
	AST_RAW_START: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RL13]
		(r.st == SMW_S_IDLE && sample_stb_i && raw_en) |=> (r.st == SMW_S_RAW))
		else $error("raw message not started on sample");
	AST_RAW_THEN_CAL: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RL20]
		(r.st == SMW_S_RAW && r.cal_pend && f_last && (!r.wvalid || out_ready_i))
		|=> (r.st == SMW_S_CAL && $stable(r.tstamp)))
		else $error("calibrated message not aligned to raw");
	AST_EMPTY_PAYLOAD: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RL2]
		(r.wvalid && r.word[29:24] == SMW_CODE_NONE) |-> (r.word[23:0] == 24'h000000))
		else $error("empty field with payload");
	AST_CAL_EQ_RAW: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RL19]
		(r.st == SMW_S_IDLE && sample_stb_i && !calib_done_i) |=> (r.cal == r.raw))
		else $error("uncalibrated data differs from raw");
	AST_EXT_TICK: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RL7]
		(in_valid_i && in_word_i[29:24] == SMW_CODE_TICK_ONE)
		|=> (ext_valid_o && ext_backward_o == $past(in_word_i[23])
			&& ext_ticks_o == $past(in_word_i[22:0])))
		else $error("tick word decoded wrongly");
	AST_EXT_GYRO_IGNORED: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RL10]
		(in_valid_i && in_word_i[29:24] == SMW_CODE_GYRO_Z) |=> !ext_valid_o)
		else $error("gyro word taken from host");
	AST_FUSION: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RL14]
		(fusion_run_i && raw_en) |=> fusion_state_flag_o)
		else $error("fusion stopped by raw output");
	AST_HOLD: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RL11]
		(out_valid_o && !out_ready_i) |=> (out_valid_o && $stable(out_word_o)))
		else $error("output word dropped under stall");
	COV_RAW_MSG: cover property (@(posedge clk_i) disable iff (!rst_n_i)
		out_valid_o && out_ready_i && out_eof_o && !out_cal_o);
	COV_CAL_MSG: cover property (@(posedge clk_i) disable iff (!rst_n_i)
		out_valid_o && out_ready_i && out_eof_o && out_cal_o);
	COV_EXT_IN: cover property (@(posedge clk_i) disable iff (!rst_n_i) ext_valid_o);

	// ==============================
	// Message layout, strobe, rate and fusion checks
	// Decoded view of the output port, so the checks read like the message layout
	logic [5:0] out_code;
	logic out_take;
	assign out_code = r.word[29:24];
	assign out_take = r.wvalid && out_ready_i;
	// Every message opens on the x-axis rate and a raw one closes on temperature
	AST_SOF_FIRST: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RL11]
		(out_valid_o && out_sof_o) |-> (out_code == SMW_CODE_GYRO_X))
		else $error("message does not open on x-axis rate");
	AST_RAW_EOF: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RL11]
		(out_valid_o && out_eof_o && !out_cal_o) |-> (out_code == SMW_CODE_TEMP))
		else $error("raw message not closed by temperature");
	AST_CAL_EOF: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RL18]
		(out_valid_o && out_eof_o && out_cal_o)
		|-> (out_code == SMW_CODE_TEMP || out_code == SMW_CODE_ACC_Z))
		else $error("calibrated message closed on wrong field");
	AST_WORD_SPARE: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RL23]
		out_valid_o |-> (r.word[31:30] == 2'b00))
		else $error("spare word bits set");
	// A strobe during a message is dropped whole, timestamp included
	AST_STROBE_BUSY: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RL12]
		(r.st != SMW_S_IDLE && sample_stb_i) |=> $stable(r.tstamp))
		else $error("busy strobe changed the timestamp");
	AST_RATE_CAPTURE: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RL13]
		cfg_stb_i |=> (r.raw_rate == $past(raw_rate_i) && r.cal_rate == $past(cal_rate_i)))
		else $error("rate setting not captured");
	AST_FUSION_OFF: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RL14]
		!fusion_run_i |=> !fusion_state_flag_o)
		else $error("fusion running without request");

	// ==============================
	// Host input checks
	// Only well-formed tick and speed words may reach the external outputs
	AST_EXT_EMPTY: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RL2]
		(in_valid_i && in_word_i[29:24] == SMW_CODE_NONE) |=> !ext_valid_o)
		else $error("empty host word taken");
	AST_EXT_RSVD: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RL23]
		(in_valid_i && in_f.kind == SMW_K_RSVD) |=> !ext_valid_o)
		else $error("reserved host word taken");
	AST_EXT_SPEED: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RL22]
		(in_valid_i && in_word_i[29:24] == SMW_CODE_SPEED)
		|=> (ext_valid_o && r.ext_speed == $past(in_word_i[23:0])))
		else $error("speed word decoded wrongly");
	AST_EXT_CODE: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RL9]
		(in_valid_i && in_f.kind == SMW_K_TICK) |=> (ext_code_o == $past(in_word_i[29:24])))
		else $error("tick word code lost");

	// ==============================
	// Scenario covers
	COV_BUSY_STROBE: cover property (@(posedge clk_i) disable iff (!rst_n_i)
		r.st != SMW_S_IDLE && sample_stb_i);
	COV_CAL_SHORT: cover property (@(posedge clk_i) disable iff (!rst_n_i)
		out_take && out_cal_o && out_eof_o && out_code == SMW_CODE_ACC_Z);
endmodule
`default_nettype wire

// ### verilog/smw_pack.sv
// Encoder that builds one measurement word from code and payload
`timescale 1ns/10ps
`default_nettype none
module smw_pack
	import smw_pkg::*;
(
	input wire logic [5:0] code_i, // Type code
	input wire logic [23:0] payload_i, // Payload
	output logic [31:0] word_o // Packed word
);
	// Empty field carries zero payload so receivers see nothing stray
	always_comb
	begin
		smw_word_t w;
		w = '0;
		w.code = code_i; // [RL23]
		w.payload = (code_i == SMW_CODE_NONE) ? '0 : payload_i; // [RL2]
		word_o = 32'(w);
	end
endmodule
`default_nettype wire

// ### verilog/smw_pkg.sv
// Package with measurement word layout, type codes and stream types
// Functional notes
// RL1: Every data field carries a 24-bit payload chosen by its type code.
// RL2: Type code zero marks an empty field; its payload is ignored.
// RL3: Code 5 is z-axis gyro rate, signed, 2^-12 deg/s units.
// RL4: Code 13 is y-axis gyro rate, same signed scaling.
// RL5: Code 14 is x-axis gyro rate, same signed scaling.
// RL6: Tick codes 8, 9, 10 hold unsigned count in low 23 bits.
// RL7: Tick payload top bit gives direction: 0 forward, 1 backward.
// RL8: Code 10 is a single speed-tick source using tick layout.
// RL9: Each field carries its own code; messages mix field types freely.
// RL10: Format works both ways: samples out, host ticks or speed in.
// RL11: Each raw message holds exactly one sample of every raw type.
// RL12: Raw sampling rate is fixed by the sensors, not configurable.
// RL13: Any non-zero raw rate setting emits at sensor sampling rate.
// RL14: Raw output enable leaves sensor fusion running.
// RL15: Raw and calibrated outputs only enable with sensors wired directly.
// RL16: Calibrated message off after reset until its rate is set.
// RL17: Non-zero calibrated rate emits at the sensor sampling rate.
// RL18: Calibrated messages carry temperature only occasionally, at lower rate.
// RL19: Calibrated data always produced; equals raw before calibration completes.
// RL20: Both streams enabled give same rate and matching timestamps.
// RL21: Host avoids enabling both streams unless port bandwidth suffices.
// RL22: Codes 11 speed, 12 temperature, 16-18 accel specific force, signed.
// RL23: Word is 32 bits: payload low 24, 6-bit code above it.
package smw_pkg;
	localparam int SMW_PAYLOAD_W = 24;
	localparam int SMW_CODE_W = 6;
	localparam int SMW_CODE_LSB = 24;
	localparam int SMW_DIR_BIT = 23;
	localparam int SMW_TICK_W = 23;
	localparam logic [5:0] SMW_CODE_NONE = 6'h00;
	localparam logic [5:0] SMW_CODE_GYRO_Z = 6'h05;
	localparam logic [5:0] SMW_CODE_TICK_RL = 6'h08;
	localparam logic [5:0] SMW_CODE_TICK_RR = 6'h09;
	localparam logic [5:0] SMW_CODE_TICK_ONE = 6'h0a;
	localparam logic [5:0] SMW_CODE_SPEED = 6'h0b;
	localparam logic [5:0] SMW_CODE_TEMP = 6'h0c;
	localparam logic [5:0] SMW_CODE_GYRO_Y = 6'h0d;
	localparam logic [5:0] SMW_CODE_GYRO_X = 6'h0e;
	localparam logic [5:0] SMW_CODE_ACC_X = 6'h10;
	localparam logic [5:0] SMW_CODE_ACC_Y = 6'h11;
	localparam logic [5:0] SMW_CODE_ACC_Z = 6'h12;
	localparam int SMW_NUM_FIELDS = 7;
	localparam int SMW_TEMP_DIV = 100;
	localparam logic [7:0] SMW_RATE_RST = 8'h00;
	// Field kinds after decode
	typedef enum logic [3:0] {
		SMW_K_NONE = 4'h0,
		SMW_K_GYRO = 4'h1,
		SMW_K_TICK = 4'h2,
		SMW_K_SIGNED = 4'h3,
		SMW_K_RSVD = 4'h4
	} smw_kind_t;
	// One measurement word on the wire
	typedef struct packed {
		logic [1:0] spare;
		logic [5:0] code;
		logic [23:0] payload;
	} smw_word_t;
	// Decoded word
	typedef struct packed {
		logic valid;
		smw_kind_t kind;
		logic [5:0] code;
		logic backward;
		logic [22:0] ticks;
		logic signed [23:0] value;
	} smw_field_t;
	// Sensor sample set
	typedef struct packed {
		logic [23:0] gyro_x;
		logic [23:0] gyro_y;
		logic [23:0] gyro_z;
		logic [23:0] acc_x;
		logic [23:0] acc_y;
		logic [23:0] acc_z;
		logic [23:0] temp;
	} smw_sample_t;
endpackage

// ### verilog/smw_unpack.sv
// Decoder that splits one measurement word into its fields
`timescale 1ns/10ps
`default_nettype none
module smw_unpack
	import smw_pkg::*;
(
	input wire logic [31:0] word_i, // Raw word
	output smw_field_t field_o // Decoded field
);
	// Decode code and payload into kind, ticks and value
	always_comb
	begin
		smw_word_t w;
		w = smw_word_t'(word_i); // [RL23]
		field_o = '0;
		field_o.code = w.code;
		field_o.ticks = w.payload[SMW_TICK_W-1:0]; // [RL6]
		field_o.backward = w.payload[SMW_DIR_BIT]; // [RL7]
		field_o.value = signed'(w.payload); // [RL1]
		case (w.code)
			SMW_CODE_NONE:
			begin
				field_o.kind = SMW_K_NONE; // [RL2]
				field_o.value = '0;
			end
			SMW_CODE_GYRO_Z, SMW_CODE_GYRO_Y, SMW_CODE_GYRO_X:
			begin
				field_o.kind = SMW_K_GYRO; // [RL3] [RL4] [RL5]
				field_o.valid = 1'b1;
			end
			SMW_CODE_TICK_RL, SMW_CODE_TICK_RR, SMW_CODE_TICK_ONE:
			begin
				field_o.kind = SMW_K_TICK; // [RL8]
				field_o.valid = 1'b1;
			end
			SMW_CODE_SPEED, SMW_CODE_TEMP, SMW_CODE_ACC_X, SMW_CODE_ACC_Y, SMW_CODE_ACC_Z:
			begin
				field_o.kind = SMW_K_SIGNED; // [RL22]
				field_o.valid = 1'b1;
			end
			default:
			begin
				field_o.kind = SMW_K_RSVD; // Reserved codes dropped
			end
		endcase
	end
endmodule
`default_nettype wire
